// ===== rtl/sfc_map.vh
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

// master clock divide down to the modulator sample rate
`define SFC_MOD_DIV        4
// fixed sinc stage: order and decimation
`define SFC_SINC_ORDER     5
`define SFC_DECIM          64
// decimated outputs discarded after a restart (sinc span plus five-stage comb pipeline)
`define SFC_FILL_COUNT     9
// reset value of the input selector: channel 0 positive, channel 1 negative
`define SFC_SEL_RESET      8'h01
// selector field positions
`define SFC_SEL_POS_MSB    7
`define SFC_SEL_POS_LSB    4
`define SFC_SEL_NEG_MSB    3
`define SFC_SEL_NEG_LSB    0
// reciprocal scaling: averaged sum times (2^24 / count), shifted down
`define SFC_RCP_SHIFT      31
// valid output rate codes
`define SFC_RATE_30000     8'hF0
`define SFC_RATE_15000     8'hE0
`define SFC_RATE_7500      8'hD0
`define SFC_RATE_3750      8'hC0
`define SFC_RATE_2000      8'hB0
`define SFC_RATE_1000      8'hA1
`define SFC_RATE_500       8'h92
`define SFC_RATE_100       8'h82
`define SFC_RATE_60        8'h72
`define SFC_RATE_50        8'h63
`define SFC_RATE_30        8'h53
`define SFC_RATE_25        8'h43
`define SFC_RATE_15        8'h33
`define SFC_RATE_10        8'h23
`define SFC_RATE_5         8'h13
`define SFC_RATE_2P5       8'h03
// reset value of the output rate code
`define SFC_RATE_RESET     8'hF0

`endif

// ===== rtl/sfc_sinc5.v
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.vh"

module sfc_sinc5 #(
  parameter ORDER = `SFC_SINC_ORDER,
  parameter DECIM = `SFC_DECIM
) (
  input  wire        clk,
  input  wire        clr,
  input  wire        ce,
  input  wire        din,
  output reg  [31:0] dout,
  output reg         dout_valid
);

  reg  [5:0]  dec_cnt_q;
  reg         tick_q;
  wire [31:0] x_in = din ? 32'h00000001 : 32'hFFFFFFFF;

  //////////////////////////////////////////////////////////////////////////////
  // decimation counter, one tick per DECIM modulator samples
  always @(posedge clk) begin
    if (clr) begin
      dec_cnt_q <= 6'h00;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (ce) begin
        if (dec_cnt_q == DECIM - 1) begin
          dec_cnt_q <= 6'h00;
          tick_q    <= 1'b1;
        end else begin
          dec_cnt_q <= dec_cnt_q + 6'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // integrators at the modulator rate, pipelined combs at the decimated rate
  genvar k;
  generate
    for (k = 0; k < ORDER; k = k + 1) begin : g_st
      reg  [31:0] integ_q;
      reg  [31:0] dly_q;
      reg  [31:0] comb_q;
      wire [31:0] integ_in = (k == 0) ? x_in : g_st[(k == 0) ? 0 : k - 1].integ_q;
      wire [31:0] comb_in  = (k == 0) ? g_st[ORDER - 1].integ_q : g_st[(k == 0) ? 0 : k - 1].comb_q;
      always @(posedge clk) begin
        if (clr) begin
          integ_q <= 32'h00000000;
          dly_q   <= 32'h00000000;
          comb_q  <= 32'h00000000;
        end else begin
          if (ce)
            integ_q <= integ_q + integ_in;
          if (tick_q) begin
            dly_q  <= comb_in;
            comb_q <= comb_in - dly_q;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // output register, wrap-around arithmetic keeps the comb result exact
  always @(posedge clk) begin
    if (clr) begin
      dout       <= 32'h00000000;
      dout_valid <= 1'b0;
    end else begin
      dout_valid <= tick_q;
      if (tick_q)
        dout <= g_st[ORDER - 1].comb_q;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/sfc_averager.v
`timescale 1ns/1ps
`default_nettype none

module sfc_averager (
  input  wire        clk,
  input  wire        clr,
  input  wire        in_valid,
  input  wire [31:0] in_data,
  input  wire [13:0] num_ave,
  input  wire [24:0] rcp,
  output reg         out_valid,
  output reg  [23:0] out_data
);

  reg  signed [45:0] sum_q;
  reg  signed [45:0] tot_q;
  reg         [13:0] cnt_q;
  reg                mul_go_q;
  reg  signed [71:0] prod_q;
  reg                clip_go_q;
  wire signed [45:0] in_ext = {{14{in_data[31]}}, in_data};
  wire signed [71:0] prod   = tot_q * $signed({1'b0, rcp});
  wire               ovf    = (prod_q[71:54] != {18{prod_q[54]}});

  //////////////////////////////////////////////////////////////////////////////
  // boxcar of num_ave decimated samples, then scale by the reciprocal
  always @(posedge clk) begin
    if (clr) begin
      sum_q     <= 46'h0;
      tot_q     <= 46'h0;
      cnt_q     <= 14'h0000;
      mul_go_q  <= 1'b0;
      prod_q    <= 72'h0;
      clip_go_q <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= 24'h000000;
    end else begin
      mul_go_q  <= 1'b0;
      clip_go_q <= mul_go_q;
      out_valid <= clip_go_q;
      if (in_valid) begin
        if (cnt_q == num_ave - 14'h0001) begin
          tot_q    <= sum_q + in_ext;
          sum_q    <= 46'h0;
          cnt_q    <= 14'h0000;
          mul_go_q <= 1'b1;
        end else begin
          sum_q <= sum_q + in_ext;
          cnt_q <= cnt_q + 14'h0001;
        end
      end
      if (mul_go_q)
        prod_q <= prod;
      // clip to full scale codes
      if (clip_go_q)
        out_data <= ovf ? (prod_q[71] ? 24'h800000 : 24'h7FFFFF) : prod_q[54:31];
    end
  end

endmodule

`default_nettype wire

// ===== rtl/sfc_conv_ctrl.v
// Overview of operation
// - response is sinc5 times averager response
// - more averages narrow bandwidth, fewer widen
// - notches at data rate and its multiples
// - first notch at data rate, tabulated bandwidth
// - response repeats at quarter master clock
// - restart to first valid result per table
// - pin high abandons conversion, resets filter
// - pin fall: ready high until settled result
// - first result after restart fully settled
// - selector 23h: channel 2 positive, 3 negative
// - previous result stays readable after restart
// - after selector change, ready once settled
// - sinc5 decimate 64 then averager
// - sixteen rate codes select averaging count
// - continuous conversions, one ready fall each
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.vh"

module sfc_conv_ctrl (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        restart_powerdown_pin,
  input  wire        modulator_bit,
  input  wire        restart_cmd,
  input  wire        wake_cmd,
  input  wire        register_write_cmd,
  input  wire [7:0]  selector_data,
  input  wire [7:0]  output_rate_code,
  output reg         result_ready_n,
  output reg  [23:0] result_data,
  output reg  [3:0]  positive_input,
  output reg  [3:0]  negative_input,
  output reg         converting
);

  // conversion states
  localparam [1:0] ST_HOLD = 2'b00;
  localparam [1:0] ST_FILL = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;
  // selector reset word, sliced into its two fields
  localparam [7:0] SEL_RST = `SFC_SEL_RESET;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         pin_s1_q;
  reg         pin_s2_q;
  reg         cmd_hold_q;
  reg  [1:0]  mod_div_q;
  reg         mod_ce_q;
  reg  [7:0]  rate_q;
  reg  [13:0] num_ave_q;
  reg  [24:0] rcp_q;
  reg  [13:0] num_ave_d;
  reg  [24:0] rcp_d;
  reg  [3:0]  fill_cnt_q;
  reg  [23:0] next_data_q;
  reg         load_q;
  wire        pin_high;
  wire        hold_req;
  wire        filt_clr;
  wire [31:0] sinc_data;
  wire        sinc_valid;
  wire        avg_valid;
  wire [23:0] avg_data;
  wire        rate_change;

  //////////////////////////////////////////////////////////////////////////////
  // synchronise the restart pin; only the second stage feeds logic
  always @(posedge mclk) begin
    if (sys_rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= restart_powerdown_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign pin_high = pin_s2_q;

  //////////////////////////////////////////////////////////////////////////////
  // restart command parks the filter until the wake command
  always @(posedge mclk) begin
    if (sys_rst)
      cmd_hold_q <= 1'b0;
    else if (restart_cmd)
      cmd_hold_q <= 1'b1;
    else if (wake_cmd)
      cmd_hold_q <= 1'b0;
  end

  // a new rate code or selector write restarts the filter
  assign rate_change = (output_rate_code != rate_q);
  assign hold_req    = pin_high | cmd_hold_q | restart_cmd;
  assign filt_clr    = (state_q == ST_HOLD) | hold_req | register_write_cmd | rate_change;

  //////////////////////////////////////////////////////////////////////////////
  // modulator sample enable at a quarter of the master clock
  always @(posedge mclk) begin
    if (sys_rst) begin
      mod_div_q <= 2'b00;
      mod_ce_q  <= 1'b0;
    end else begin
      mod_div_q <= mod_div_q + 2'b01;
      mod_ce_q  <= (mod_div_q == `SFC_MOD_DIV - 1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // rate code to averaging count and reciprocal scale
  always @* begin
    case (rate_q)
      `SFC_RATE_30000: begin
        num_ave_d = 14'h0001;
        rcp_d     = 25'h1000000;
      end
      `SFC_RATE_15000: begin
        num_ave_d = 14'h0002;
        rcp_d     = 25'h0800000;
      end
      `SFC_RATE_7500: begin
        num_ave_d = 14'h0004;
        rcp_d     = 25'h0400000;
      end
      `SFC_RATE_3750: begin
        num_ave_d = 14'h0008;
        rcp_d     = 25'h0200000;
      end
      `SFC_RATE_2000: begin
        num_ave_d = 14'h000F;
        rcp_d     = 25'h0111111;
      end
      `SFC_RATE_1000: begin
        num_ave_d = 14'h001E;
        rcp_d     = 25'h0088889;
      end
      `SFC_RATE_500: begin
        num_ave_d = 14'h003C;
        rcp_d     = 25'h0044444;
      end
      `SFC_RATE_100: begin
        num_ave_d = 14'h012C;
        rcp_d     = 25'h000DA74;
      end
      `SFC_RATE_60: begin
        num_ave_d = 14'h01F4;
        rcp_d     = 25'h0008312;
      end
      `SFC_RATE_50: begin
        num_ave_d = 14'h0258;
        rcp_d     = 25'h0006D3A;
      end
      `SFC_RATE_30: begin
        num_ave_d = 14'h03E8;
        rcp_d     = 25'h0004189;
      end
      `SFC_RATE_25: begin
        num_ave_d = 14'h04B0;
        rcp_d     = 25'h000369D;
      end
      `SFC_RATE_15: begin
        num_ave_d = 14'h07D0;
        rcp_d     = 25'h00020C5;
      end
      `SFC_RATE_10: begin
        num_ave_d = 14'h0BB8;
        rcp_d     = 25'h00015D8;
      end
      `SFC_RATE_5: begin
        num_ave_d = 14'h1770;
        rcp_d     = 25'h0000AEC;
      end
      `SFC_RATE_2P5: begin
        num_ave_d = 14'h2EE0;
        rcp_d     = 25'h0000576;
      end
      // unlisted codes fall back to the bypassed averager
      default: begin
        num_ave_d = 14'h0001;
        rcp_d     = 25'h1000000;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // rate code and its count are captured so they stay fixed mid-conversion
  always @(posedge mclk) begin
    if (sys_rst) begin
      rate_q    <= `SFC_RATE_RESET;
      num_ave_q <= 14'h0001;
      rcp_q     <= 25'h1000000;
    end else begin
      rate_q    <= output_rate_code;
      num_ave_q <= num_ave_d;
      rcp_q     <= rcp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input selector, written by the register write strobe
  always @(posedge mclk) begin
    if (sys_rst) begin
      positive_input <= SEL_RST[`SFC_SEL_POS_MSB:`SFC_SEL_POS_LSB];
      negative_input <= SEL_RST[`SFC_SEL_NEG_MSB:`SFC_SEL_NEG_LSB];
    end else if (register_write_cmd) begin
      positive_input <= selector_data[`SFC_SEL_POS_MSB:`SFC_SEL_POS_LSB];
      negative_input <= selector_data[`SFC_SEL_NEG_MSB:`SFC_SEL_NEG_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fixed fifth-order sinc, decimation by 64 at a quarter master clock
  sfc_sinc5 #(
    .ORDER (`SFC_SINC_ORDER),
    .DECIM (`SFC_DECIM)
  ) u_sinc (
    .clk        (mclk),
    .clr        (filt_clr),
    .ce         (mod_ce_q),
    .din        (modulator_bit),
    .dout       (sinc_data),
    .dout_valid (sinc_valid)
  );

  //////////////////////////////////////////////////////////////////////////////
  // programmable averager fed only with settled sinc outputs
  sfc_averager u_avg (
    .clk       (mclk),
    .clr       (filt_clr),
    .in_valid  (sinc_valid & (state_q == ST_RUN)),
    .in_data   (sinc_data),
    .num_ave   (num_ave_q),
    .rcp       (rcp_q),
    .out_valid (avg_valid),
    .out_data  (avg_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // conversion sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (!hold_req)
          state_d = ST_FILL;
      end
      ST_FILL: begin
        if (filt_clr)
          state_d = ST_HOLD;
        else if (sinc_valid && fill_cnt_q == `SFC_FILL_COUNT - 1)
          state_d = ST_RUN;
      end
      ST_RUN: begin
        if (filt_clr)
          state_d = ST_HOLD;
      end
      default: state_d = ST_HOLD;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register and fill counter
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_q    <= ST_HOLD;
      fill_cnt_q <= 4'h0;
      converting <= 1'b0;
    end else begin
      state_q    <= state_d;
      converting <= (state_d != ST_HOLD);
      if (state_q != ST_FILL || filt_clr)
        fill_cnt_q <= 4'h0;
      else if (sinc_valid)
        fill_cnt_q <= fill_cnt_q + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result handoff: ready rises one cycle, data updates, ready falls
  always @(posedge mclk) begin
    if (sys_rst) begin
      result_ready_n <= 1'b1;
      result_data    <= 24'h000000;
      next_data_q    <= 24'h000000;
      load_q         <= 1'b0;
    end else begin
      load_q <= 1'b0;
      if (filt_clr) begin
        result_ready_n <= 1'b1;
      end else if (avg_valid && state_q == ST_RUN) begin
        result_ready_n <= 1'b1;
        next_data_q    <= avg_data;
        load_q         <= 1'b1;
      end else if (load_q) begin
        result_data    <= next_data_q;
        result_ready_n <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ===== test/sfc_conv_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.vh"
////////////////////////////////////////////////////////////
module sfc_conv_ctrl_sva (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        restart_powerdown_pin,
  input wire logic        restart_cmd,
  input wire logic        wake_cmd,
  input wire logic        register_write_cmd,
  input wire logic [7:0]  selector_data,
  input wire logic [7:0]  output_rate_code,
  input wire logic        result_ready_n,
  input wire logic [23:0] result_data,
  input wire logic [3:0]  positive_input,
  input wire logic [3:0]  negative_input,
  input wire logic        converting
);
  localparam int FIRST_MIN = (`SFC_FILL_COUNT + 1) * `SFC_DECIM * `SFC_MOD_DIV;
  logic        rdy_q;
  logic        seen_q;
  logic [11:0] run_q;
  logic [11:0] gap_q;
  logic [7:0]  sel_q;
  logic [7:0]  rate_q;
  wire         fall_w = rdy_q & ~result_ready_n;
  wire         fast_w = output_rate_code == `SFC_RATE_30000 || output_rate_code == `SFC_RATE_15000;
  wire  [11:0] per_w  = (output_rate_code == `SFC_RATE_30000) ? 12'h100 : 12'h200;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // run length since start and gap between results
  always @(posedge mclk) begin
    rdy_q <= sys_rst | result_ready_n;
    rate_q <= output_rate_code;
    gap_q <= fall_w ? 12'h001 : gap_q + 12'h001;
    if (register_write_cmd)
      sel_q <= selector_data;
    if (sys_rst || !converting || rate_q != output_rate_code) begin
      run_q <= 12'h000;
      seen_q <= 1'b0;
    end else begin
      if (run_q != 12'hFFF)
        run_q <= run_q + 12'h001;
      if (fall_w)
        seen_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  sequence hold_s;
    restart_cmd ##1 (!wake_cmd)[*3];
  endsequence
  sequence wake_s;
    (!restart_powerdown_pin)[*4] ##0 (wake_cmd && !restart_cmd);
  endsequence

  cmd_ready_a: assert property (restart_cmd || register_write_cmd |=> result_ready_n)
    else $error("ready not raised by restart");
  cmd_hold_a: assert property (hold_s |-> !converting && result_ready_n)
    else $error("filter not held until wake");
  wake_run_a: assert property (wake_s |-> ##[1:4] converting)
    else $error("wake did not start conversion");
  pin_hold_a: assert property (restart_powerdown_pin[*6] |-> !converting && result_ready_n)
    else $error("pin high did not hold filter");
  sel_update_a: assert property (register_write_cmd ##1 !register_write_cmd
    |-> ##1 {positive_input, negative_input} == sel_q) else $error("selector fields wrong");
  data_hold_a: assert property ($changed(result_data) |-> $fell(result_ready_n))
    else $error("result changed outside ready fall");
  first_settle_a: assert property ($fell(result_ready_n) |-> run_q >= FIRST_MIN)
    else $error("result before settling");
  result_period_a: assert property ($fell(result_ready_n) && seen_q && fast_w |-> gap_q == per_w)
    else $error("result period wrong");
endmodule

bind sfc_conv_ctrl sfc_conv_ctrl_sva chk (.mclk, .sys_rst, .restart_powerdown_pin, .restart_cmd,
  .wake_cmd, .register_write_cmd, .selector_data, .output_rate_code, .result_ready_n,
  .result_data, .positive_input, .negative_input, .converting);
`default_nettype wire

// ===== test/sfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module sfc_host_model (
  input  wire logic      mclk,
  output var logic       restart_powerdown_pin,
  output var logic       modulator_bit,
  output var logic       restart_cmd,
  output var logic       wake_cmd,
  output var logic       register_write_cmd,
  output var logic [7:0] selector_data
);
  logic lvl = 1'b1;

  // all strobes idle at start
  initial begin
    restart_powerdown_pin = 1'b0;
    modulator_bit = 1'b1;
    restart_cmd = 1'b0;
    wake_cmd = 1'b0;
    register_write_cmd = 1'b0;
    selector_data = 8'h00;
  end

  // bitstream level chosen by the bench
  always @(negedge mclk)
    modulator_bit <= lvl;

  // one-cycle command strobe, data scrambled after use
  task automatic strobe(input int k, input logic [7:0] d);
    @(negedge mclk);
    selector_data = d;
    restart_cmd = (k == 0);
    wake_cmd = (k == 1);
    register_write_cmd = (k == 2);
    @(negedge mclk);
    restart_cmd = 1'b0;
    wake_cmd = 1'b0;
    register_write_cmd = 1'b0;
    selector_data = ~d;
  endtask

  // channel switch at a ready fall, then restart and wake
  task automatic mux_cycle(input logic [7:0] sel, input int gap);
    strobe(2, sel);
    strobe(0, ~sel);
    repeat (gap) @(negedge mclk);
    strobe(1, sel);
  endtask

  // hold the restart pin high for n cycles
  task automatic pin_strobe(input int n);
    @(negedge mclk);
    restart_powerdown_pin = 1'b1;
    repeat (n) @(negedge mclk);
    restart_powerdown_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfc_map.vh"
////////////////////////////////////////////////////////////
module testbench;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  output_rate_code = 8'hF0;
  wire         restart_powerdown_pin;
  wire         modulator_bit;
  wire         restart_cmd;
  wire         wake_cmd;
  wire         register_write_cmd;
  wire  [7:0]  selector_data;
  wire         result_ready_n;
  wire  [23:0] result_data;
  wire  [3:0]  positive_input;
  wire  [3:0]  negative_input;
  wire         converting;
  int          err_total = 0;
  int          check_count = 0;

  always #2 mclk = ~mclk;

  sfc_conv_ctrl uut (.mclk, .sys_rst, .restart_powerdown_pin, .modulator_bit, .restart_cmd,
    .wake_cmd, .register_write_cmd, .selector_data, .output_rate_code, .result_ready_n,
    .result_data, .positive_input, .negative_input, .converting);
  sfc_host_model host (.mclk, .restart_powerdown_pin, .modulator_bit, .restart_cmd, .wake_cmd,
    .register_write_cmd, .selector_data);

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // fill plus averages, with a little pipeline slack
  task automatic in_win(input int n, input int na);
    check(n >= (`SFC_FILL_COUNT + na) * 256 && n <= (`SFC_FILL_COUNT + na) * 256 + 64, 1);
  endtask

  // count falling edges until ready shows the level
  task automatic wait_rdy(input logic lvl, output int n);
    n = 0;
    while (result_ready_n !== lvl && n < 20000) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // first result after reset, full scale
  task automatic t_first();
    int n;
    wait_rdy(1'b0, n);
    in_win(n, 1);
    check(result_data, 24'h7FFFFF);
  endtask

  // steady results, one high cycle before each
  task automatic t_cont();
    int a;
    int b;
    repeat (3) begin
      wait_rdy(1'b1, a);
      wait_rdy(1'b0, b);
      check(b, 1);
      check(a + b, 256);
    end
  endtask

  // rate change restarts and sets the period
  task automatic t_rate(input logic [7:0] code, input int na);
    int a;
    int b;
    output_rate_code = code;
    wait_rdy(1'b1, a);
    wait_rdy(1'b0, b);
    in_win(a + b, na);
    wait_rdy(1'b1, a);
    wait_rdy(1'b0, b);
    check(a + b, na * 256);
  endtask

  // pin strobe abandons and restarts
  task automatic t_pin();
    logic [23:0] d;
    int n;
    d = result_data;
    host.pin_strobe(20);
    check(converting, 0);
    check(result_ready_n, 1);
    check(result_data, d);
    wait_rdy(1'b0, n);
    in_win(n, 1);
  endtask

  // restart command holds until wake, all-zero bitstream gives a negative result
  task automatic t_hold();
    int n;
    host.lvl = 1'b0;
    host.strobe(0, 8'h00);
    repeat (600) @(negedge mclk);
    check(converting, 0);
    check(result_ready_n, 1);
    host.strobe(1, 8'h00);
    wait_rdy(1'b0, n);
    in_win(n, 1);
    check(result_data[23], 1);
  endtask

  // channel cycling at a ready fall
  task automatic t_mux(input logic [7:0] sel);
    logic [23:0] d;
    int n;
    d = result_data;
    host.lvl = 1'b1;
    host.mux_cycle(sel, 2);
    check(positive_input, sel[7:4]);
    check(negative_input, sel[3:0]);
    check(result_data, d);
    wait_rdy(1'b0, n);
    in_win(n, 1);
    check(result_data, 24'h7FFFFF);
  endtask

  // slow mains-rejecting rate: still settling after a short span
  task automatic t_slow();
    output_rate_code = `SFC_RATE_60;
    repeat (3000) @(negedge mclk);
    check(result_ready_n, 1);
    check(converting, 1);
  endtask

  // main sequence
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    t_first();
    t_cont();
    t_pin();
    t_hold();
    t_mux(8'h23);
    t_mux(8'h45);
    t_rate(8'hE0, 2);
    t_rate(8'hD0, 4);
    t_rate(8'hC0, 8);
    t_rate(8'hB0, 15);
    t_slow();
    t_rate(8'hF0, 1);
    wrap_up();
  end

  // watchdog against a hang
  initial begin
    #300000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
